/* logic/rcs_pkg.sv */
/*
 * Shared constants, types and the illegal-address gap bounds for the
 * reset cause and system options block.
 * Assumes an 8-bit CPU data bus with a 16-bit address, all on one bus clock.
 */
package rcs_pkg;
    // Register addresses in the upper register page
    localparam logic [15:0] RCS_STATUS_ADDR  = 16'h1800;
    localparam logic [15:0] RCS_FORCE_ADDR   = 16'h1801;
    localparam logic [15:0] RCS_OPTIONS_ADDR = 16'h1802;
    // Reset cause status bit positions
    localparam int RCS_B_PWR_ON = 7;
    localparam int RCS_B_PIN    = 6;
    localparam int RCS_B_WDOG   = 5;
    localparam int RCS_B_ILLOP  = 4;
    localparam int RCS_B_ILLAD  = 3;
    localparam int RCS_B_CLKMOD = 2;
    localparam int RCS_B_LOWV   = 1;
    // Force-reset control bit position
    localparam int RCS_B_FORCE  = 0;
    // Options bit positions
    localparam int RCS_B_WDOG_EN  = 7;
    localparam int RCS_B_WDOG_LNG = 6;
    localparam int RCS_B_HALT_OK  = 5;
    localparam int RCS_B_DBG_PIN  = 1;
    // Reset and read values
    localparam logic [7:0] RCS_STATUS_POR = 8'h82;
    localparam logic [7:0] RCS_OPT_RESET  = 8'hc2;
    localparam logic [7:0] RCS_OPT_MASK   = 8'he2;
    localparam logic [7:0] RCS_FORCE_READ = 8'h00;
    // Illegal address gaps
    localparam logic [15:0] RCS_GAP0_LO = 16'h0880;
    localparam logic [15:0] RCS_GAP0_HI = 16'h17ff;
    localparam logic [15:0] RCS_GAP1_LO = 16'h182c;
    localparam logic [15:0] RCS_GAP1_HI = 16'hbfff;
    // Watchdog timeout lengths in bus-clock cycles
    localparam int          RCS_WDOG_SHORT_EXP = 13;
    localparam int          RCS_WDOG_LONG_EXP  = 18;
    localparam logic [18:0] RCS_WDOG_SHORT_CYC = 19'h00001 << RCS_WDOG_SHORT_EXP;
    localparam logic [18:0] RCS_WDOG_LONG_CYC  = 19'h00001 << RCS_WDOG_LONG_EXP;
    // Default length of the internal reset pulse
    localparam int RCS_HOLD_CYC = 16;

    // Sequencer states, Gray along run/hold
    typedef enum logic [1:0] {
        RCS_RUN  = 2'b00,
        RCS_HOLD = 2'b01
    } rcs_state_t;

    // Reset sources seen in one cycle
    typedef struct packed {
        logic pwr_on;   // Power-on
        logic pin;      // External reset pin
        logic wdog;     // Watchdog timeout
        logic illop;    // Illegal opcode
        logic illad;    // Illegal address
        logic clkmod;   // Clock module reset
        logic lowv;     // Low-voltage trip
    } rcs_cause_t;
endpackage

/* logic/rcs_gap_decode.sv */
/*
 * Illegal address gap decoder.
 * Assumes a stable address whenever the access strobe is high.
 */
`timescale 1ns/100ps
module rcs_gap_decode (
    input  wire logic [15:0] addr_i,    // Bus address
    input  wire logic        access_i,  // Read or write in progress
    output logic             illegal_o  // Access falls in a gap
);
    // Two gaps; register pages themselves never decode as illegal
    assign illegal_o = access_i &&
        (((addr_i >= rcs_pkg::RCS_GAP0_LO) && (addr_i <= rcs_pkg::RCS_GAP0_HI)) ||
         ((addr_i >= rcs_pkg::RCS_GAP1_LO) && (addr_i <= rcs_pkg::RCS_GAP1_HI)));
endmodule

/* logic/rcs_reset_cause.sv */
/*
 * Reset cause recorder, debug force reset and write-once system options.
 * Assumes rstn_i is the power-on reset, bus strobes come from the CPU on
 * clk_i, and sys_reset_o drives the chip reset generator.
 */
`timescale 1ns/100ps
module rcs_reset_cause #(
    parameter int HOLD_CYC = rcs_pkg::RCS_HOLD_CYC  // Internal reset length
) (
    input  wire logic        clk_i,                          // Bus clock
    input  wire logic        rstn_i,                         // Power-on reset, low
    input  wire logic [15:0] bus_addr_i,                     // CPU address
    input  wire logic        bus_rd_i,                       // Read strobe
    input  wire logic        bus_wr_i,                       // Write strobe
    input  wire logic [7:0]  bus_wdata_i,                    // Write data
    input  wire logic        bus_dbg_i,                      // Access from debug port
    output logic      [7:0]  bus_rdata_o,                    // Read data, next cycle
    input  wire logic        reset_pin_n_i,                  // External reset pin, low
    input  wire logic        wdog_expired_i,                 // Watchdog timed out
    input  wire logic        opcode_illegal_i,               // Unimplemented opcode
    input  wire logic        halt_exec_i,                    // Halt instruction
    input  wire logic        enter_background_instruction_exec_i,                    // Background instruction
    input  wire logic        background_mode_permit_i,       // Background mode allowed
    input  wire logic        clock_module_reset_i,           // Clock module request
    input  wire logic        supply_low_i,                   // Detector below trip
    input  wire logic        voltage_detector_enable_i,      // Detector enable
    input  wire logic        voltage_detector_reset_enable_i,// Detector reset enable
    input  wire logic        voltage_detector_stop_enable_i, // Detector kept in stop
    input  wire logic        stop_mode_i,                    // Device is in stop
    input  wire logic        pg0_data_i,                     // Port bit value
    output logic             sys_reset_o,                    // Reset to generator
    output logic             wdog_restart_o,                 // Watchdog restart pulse
    output logic             watchdog_enable_option_o,       // Watchdog enabled
    output logic             watchdog_timeout_option_o,      // Long timeout chosen
    output logic      [18:0] wdog_timeout_cycles_o,          // Timeout in cycles
    output logic             halt_permit_option_o,           // Stop mode allowed
    output logic             stop_enter_o,                   // Enter stop pulse
    output logic             lv_detect_active_o,             // Detector running
    output logic             debug_pin_enable_option_o,      // Pin is debug line
    output logic             pg0_o,                          // Port bit drive value
    output logic             pg0_oe_n_o                      // Port drive enable, low
);
    // Synchronisers for asynchronous pins
    logic                pin_meta_q;      // Reset pin stage 1
    logic                pin_sync_q;      // Reset pin stage 2
    logic                low_meta_q;      // Supply low stage 1
    logic                low_sync_q;      // Supply low stage 2
    // Sequencer and register state
    rcs_pkg::rcs_state_t state_q, state_d;          // Run or hold
    logic [7:0]          cnt_q, cnt_d;              // Hold cycle count
    logic [7:0]          status_q, status_d;        // Reset causes
    logic [7:0]          opt_q, opt_d;              // Options byte
    logic                locked_q, locked_d;        // Options written once
    logic [7:0]          rdata_q, rdata_d;          // Read data
    logic                restart_q, restart_d;      // Watchdog restart
    logic                stop_q, stop_d;            // Stop entry
    logic                lvact_q, lvact_d;          // Detector active
    logic                pg0_q, pg0_d;              // Port value
    logic                pg0_oe_n_q, pg0_oe_n_d;    // Port enable
    // Decoded events
    rcs_pkg::rcs_cause_t src;            // Sources this cycle
    logic                gap_hit;        // Access in illegal gap
    logic                force_hit;      // Debug force write
    logic                other_src;      // Any source except address
    logic                any_src;        // Any reset request
    logic                bus_ok;         // Bus served this cycle
    // Address match, used by read and write paths
    function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
        hit = (a == r);
    endfunction
    // Pack causes into the status byte layout
    function automatic logic [7:0] cause_byte(input rcs_pkg::rcs_cause_t c);
        logic [7:0] b;
        b = 8'h00;
        b[rcs_pkg::RCS_B_PWR_ON] = c.pwr_on;
        b[rcs_pkg::RCS_B_PIN]    = c.pin;
        b[rcs_pkg::RCS_B_WDOG]   = c.wdog;
        b[rcs_pkg::RCS_B_ILLOP]  = c.illop;
        b[rcs_pkg::RCS_B_ILLAD]  = c.illad;
        b[rcs_pkg::RCS_B_CLKMOD] = c.clkmod;
        b[rcs_pkg::RCS_B_LOWV]   = c.lowv;
        return b;
    endfunction
    // Gap decoder for illegal accesses
    // gap ranges only
    rcs_gap_decode u_gap (
        .addr_i    (bus_addr_i),
        .access_i  (bus_rd_i | bus_wr_i),
        .illegal_o (gap_hit)
    );
    // Two-stage synchronisers, reset inactive
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
            low_meta_q <= 1'b0;
            low_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= reset_pin_n_i;
            pin_sync_q <= pin_meta_q;
            low_meta_q <= supply_low_i;
            low_sync_q <= low_meta_q;
        end
    end
    // Source decode
    always_comb begin
        src        = '0;
        src.pin    = ~pin_sync_q;
        src.wdog   = wdog_expired_i & opt_q[rcs_pkg::RCS_B_WDOG_EN];
        src.illop  = opcode_illegal_i
                   | (halt_exec_i & ~opt_q[rcs_pkg::RCS_B_HALT_OK])
                   | (enter_background_instruction_exec_i & ~background_mode_permit_i);
        src.illad  = gap_hit;
        src.clkmod = clock_module_reset_i;
        src.lowv   = low_sync_q & voltage_detector_enable_i
                   & voltage_detector_reset_enable_i & lvact_q;
        // only debug-port writes of 1 count
        force_hit  = bus_wr_i & bus_dbg_i & hit(bus_addr_i, rcs_pkg::RCS_FORCE_ADDR)
                   & bus_wdata_i[rcs_pkg::RCS_B_FORCE];
        other_src  = src.pin | src.wdog | src.illop | src.clkmod | src.lowv | force_hit;
        any_src    = other_src | src.illad;
    end
    // Next-state logic for sequencer, flags, options and bus
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        status_d   = status_q;
        opt_d      = opt_q;
        locked_d   = locked_q;
        rdata_d    = 8'h00;
        restart_d  = 1'b0;
        stop_d     = 1'b0;
        pg0_d      = pg0_data_i;
        bus_ok     = 1'b0;
        // detector stops in stop mode unless kept
        lvact_d    = voltage_detector_enable_i
                   & (~stop_mode_i | voltage_detector_stop_enable_i);
        // pin released to debug unless option clear
        pg0_oe_n_d = opt_q[rcs_pkg::RCS_B_DBG_PIN];
        case (state_q)
            rcs_pkg::RCS_RUN: begin
                if (any_src) begin
                    // Enter internal reset and record causes
                    state_d  = rcs_pkg::RCS_HOLD;
                    cnt_d    = 8'h00;
                    opt_d    = rcs_pkg::RCS_OPT_RESET;
                    locked_d = 1'b0;
                    if (src.lowv) begin
                        // Low-voltage: power-on bit unaffected
                        status_d = (status_q & (8'h01 << rcs_pkg::RCS_B_PWR_ON))
                                 | (8'h01 << rcs_pkg::RCS_B_LOWV);
                    end else begin
                        status_d = cause_byte(src);
                    end
                end else begin
                    bus_ok = 1'b1;
                end
            end
            rcs_pkg::RCS_HOLD: begin
                // sources active during reset also flagged
                status_d = status_q | cause_byte(src);
                cnt_d    = cnt_q + 8'h01;
                if (cnt_q == 8'(HOLD_CYC - 1)) begin
                    state_d = rcs_pkg::RCS_RUN;
                end
            end
            default: begin
                state_d = rcs_pkg::RCS_HOLD;
                cnt_d   = 8'h00;
            end
        endcase
        if (bus_ok) begin
            // Reads answer one cycle later
            if (bus_rd_i) begin
                if (hit(bus_addr_i, rcs_pkg::RCS_STATUS_ADDR)) begin
                    rdata_d = status_q;
                end else if (hit(bus_addr_i, rcs_pkg::RCS_OPTIONS_ADDR)) begin
                    rdata_d = opt_q & rcs_pkg::RCS_OPT_MASK;
                end else begin
                    rdata_d = rcs_pkg::RCS_FORCE_READ;
                end
            end
            if (bus_wr_i && hit(bus_addr_i, rcs_pkg::RCS_STATUS_ADDR)) begin
                restart_d = 1'b1;
            end
            // first write after reset locks options
            if (bus_wr_i && hit(bus_addr_i, rcs_pkg::RCS_OPTIONS_ADDR) && !locked_q) begin
                opt_d    = bus_wdata_i & rcs_pkg::RCS_OPT_MASK;
                locked_d = 1'b1;
            end
            // Halt with permit enters stop
            stop_d = halt_exec_i & opt_q[rcs_pkg::RCS_B_HALT_OK];
        end
    end
    // State registers; power-on starts in hold
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q    <= rcs_pkg::RCS_HOLD;
            cnt_q      <= 8'h00;
            status_q   <= rcs_pkg::RCS_STATUS_POR;
            opt_q      <= rcs_pkg::RCS_OPT_RESET;
            locked_q   <= 1'b0;
            rdata_q    <= 8'h00;
            restart_q  <= 1'b0;
            stop_q     <= 1'b0;
            lvact_q    <= 1'b0;
            pg0_q      <= 1'b0;
            pg0_oe_n_q <= 1'b1;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            status_q   <= status_d;
            opt_q      <= opt_d;
            locked_q   <= locked_d;
            rdata_q    <= rdata_d;
            restart_q  <= restart_d;
            stop_q     <= stop_d;
            lvact_q    <= lvact_d;
            pg0_q      <= pg0_d;
            pg0_oe_n_q <= pg0_oe_n_d;
        end
    end
    // Output drive
    assign sys_reset_o               = (state_q == rcs_pkg::RCS_HOLD);
    assign bus_rdata_o               = rdata_q;
    assign wdog_restart_o            = restart_q;
    assign stop_enter_o              = stop_q;
    assign lv_detect_active_o        = lvact_q;
    assign watchdog_enable_option_o  = opt_q[rcs_pkg::RCS_B_WDOG_EN];
    assign watchdog_timeout_option_o = opt_q[rcs_pkg::RCS_B_WDOG_LNG];
    assign halt_permit_option_o      = opt_q[rcs_pkg::RCS_B_HALT_OK];
    assign debug_pin_enable_option_o = opt_q[rcs_pkg::RCS_B_DBG_PIN];
    assign pg0_o                     = pg0_q;
    assign pg0_oe_n_o                = pg0_oe_n_q;
    assign wdog_timeout_cycles_o     = opt_q[rcs_pkg::RCS_B_WDOG_LNG]
                                     ? rcs_pkg::RCS_WDOG_LONG_CYC
                                     : rcs_pkg::RCS_WDOG_SHORT_CYC;

    // Checks on the design's own registers and outputs
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    AST_FORCE_READ_ZERO: assert property (
        bus_ok && bus_rd_i && bus_addr_i == rcs_pkg::RCS_FORCE_ADDR |=> bus_rdata_o == 8'h00)
        else $error("force register read not zero");
    AST_OPT_HOLES_ZERO: assert property (
        bus_ok && bus_rd_i && bus_addr_i == rcs_pkg::RCS_OPTIONS_ADDR
        |=> bus_rdata_o[3:2] == 2'b00 && bus_rdata_o == $past(opt_q))
        else $error("options read wrong");
    AST_WRITE_ONCE: assert property (
        locked_q && !any_src && state_q == rcs_pkg::RCS_RUN |=> $stable(opt_q))
        else $error("options changed after lock");
    AST_USER_FORCE_IGNORED: assert property (
        bus_ok && bus_wr_i && !bus_dbg_i && bus_addr_i == rcs_pkg::RCS_FORCE_ADDR
        && !any_src |=> !sys_reset_o)
        else $error("user write forced reset");
    AST_DBG_FORCE_CLEAN: assert property (
        state_q == rcs_pkg::RCS_RUN && force_hit && cause_byte(src) == 8'h00
        |=> sys_reset_o && status_q == 8'h00)
        else $error("debug force reset wrong");
    AST_HALT_ILLEGAL: assert property (
        state_q == rcs_pkg::RCS_RUN && halt_exec_i && !halt_permit_option_o && !src.lowv
        |=> sys_reset_o && status_q[rcs_pkg::RCS_B_ILLOP] && !stop_enter_o)
        else $error("halt without permit not illegal");
    AST_GAP_RESET: assert property (
        state_q == rcs_pkg::RCS_RUN && bus_rd_i && bus_addr_i == 16'h0880
        && !other_src |=> sys_reset_o && status_q == 8'h08)
        else $error("gap access missed");
    AST_REG_HOLE_OK: assert property (
        state_q == rcs_pkg::RCS_RUN && bus_rd_i && bus_addr_i == 16'h182b
        && !other_src |=> !sys_reset_o)
        else $error("register hole reset");
    AST_WDOG_GATED: assert property (
        state_q == rcs_pkg::RCS_RUN && wdog_expired_i && !opt_q[7] && !src.illad
        && !other_src |=> !sys_reset_o)
        else $error("disabled watchdog reset");
    AST_STATUS_RESTART: assert property (
        bus_ok && bus_wr_i && bus_addr_i == rcs_pkg::RCS_STATUS_ADDR
        |=> wdog_restart_o && $stable(status_q))
        else $error("status write effect wrong");
    AST_FLAGS_STABLE: assert property (
        state_q == rcs_pkg::RCS_RUN && $past(state_q) == rcs_pkg::RCS_RUN
        |-> $stable(status_q))
        else $error("flags changed in run");
    AST_OPT_DEFAULT: assert property (
        $fell(sys_reset_o) |-> opt_q == 8'hc2 && !locked_q)
        else $error("options not default after reset");
    AST_LV_STOP: assert property (
        stop_mode_i && !voltage_detector_stop_enable_i |=> !lv_detect_active_o)
        else $error("detector active in stop");

    COV_DBG_FORCE: cover property (state_q == rcs_pkg::RCS_RUN && force_hit);
    COV_GAP: cover property (state_q == rcs_pkg::RCS_RUN && src.illad);
    COV_OPT_WRITE: cover property (bus_ok && bus_wr_i && !locked_q
        && bus_addr_i == rcs_pkg::RCS_OPTIONS_ADDR);
    COV_LOWV: cover property (state_q == rcs_pkg::RCS_RUN && src.lowv);
endmodule

/* dv/rcs_dbg_host.sv */
/*
 * Debug host model: issues background memory writes.
 * Assumes the bench steers these lines onto the CPU bus while wr_o is high.
 */
`timescale 1ns/100ps
module rcs_dbg_host (
    input  wire logic        clk_i,   // Bus clock
    output logic             wr_o,    // Write strobe
    output logic      [15:0] addr_o,  // Write address
    output logic      [7:0]  wdata_o  // Write data
);
    // Idle lines at time zero
    initial begin
        wr_o = 1'b0;
        addr_o = 16'h0000;
        wdata_o = 8'h00;
    end
    task automatic write_byte(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(negedge clk_i);
        wr_o = 1'b0;
        // Released lines show no stale value
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule

/* dv/testbench.sv */
/*
 * Bench for the reset cause block: register rows, then reset sources.
 * Assumes the debug host model drives debug writes.
 */
`timescale 1ns/100ps
module testbench;
    typedef struct packed {logic w; logic [15:0] a; logic [7:0] d; logic [7:0] e;} rcs_row_t;
    typedef struct packed {logic [3:0] k; logic [15:0] a; logic [7:0] e;} rcs_crow_t;
    logic clk_i = 1'b0, rstn_i = 1'b0, c_rd = 1'b0, c_wr = 1'b0, pin_n = 1'b1;
    logic low = 1'b0, stp = 1'b0, stpen = 1'b0, pg0 = 1'b1, dh_wr;
    logic bmp = 1'b0, lvre = 1'b1;   // Background permit, detector reset enable
    logic [4:0]  src = 5'h00;        // Pulsed reset sources
    logic [15:0] c_a = 16'h0000, dh_a;
    logic [7:0]  c_d = 8'h00, dh_d, rdata;
    logic        sres, wrst, wen, wlong, hok, sten, lva, dpin, pg0o, oen;
    logic [18:0] cyc;
    int          err_total = 0;
    int          samples_checked = 0;
    rcs_row_t    rows [11] = '{'{0, 16'h1800, 8'h00, 8'h82}, '{0, 16'h1802, 8'h00, 8'hc2},
        '{0, 16'h1801, 8'h00, 8'h00}, '{1, 16'h1801, 8'h01, 8'h00},
        '{1, 16'h1800, 8'hff, 8'h00}, '{0, 16'h1800, 8'h00, 8'h82},
        '{0, 16'h182b, 8'h00, 8'h00}, '{1, 16'h1802, 8'hff, 8'h00},
        '{0, 16'h1802, 8'h00, 8'he2}, '{1, 16'h1802, 8'h00, 8'h00},
        '{0, 16'h1802, 8'h00, 8'he2}};
    rcs_crow_t   causes [12] = '{'{0, 0, 8'h20}, '{1, 0, 8'h10}, '{3, 0, 8'h10},
        '{4, 0, 8'h10}, '{2, 0, 8'h04}, '{5, 16'h0880, 8'h08}, '{5, 16'h17ff, 8'h08},
        '{5, 16'h182c, 8'h08}, '{5, 16'hbfff, 8'h08}, '{6, 0, 8'h40},
        '{7, 0, 8'h02}, '{8, 0, 8'h00}};
    // Clock at 20 MHz
    always #25 clk_i = ~clk_i;
    rcs_dbg_host dbg_host_i (.clk_i(clk_i), .wr_o(dh_wr), .addr_o(dh_a), .wdata_o(dh_d));
    rcs_reset_cause #(.HOLD_CYC(4)) rcs_reset_cause_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .bus_addr_i(dh_wr ? dh_a : c_a), .bus_rd_i(c_rd),
        .bus_wr_i(c_wr | dh_wr), .bus_wdata_i(dh_wr ? dh_d : c_d), .bus_dbg_i(dh_wr),
        .bus_rdata_o(rdata), .reset_pin_n_i(pin_n), .wdog_expired_i(src[0]),
        .opcode_illegal_i(src[1]), .halt_exec_i(src[3]), .enter_background_instruction_exec_i(src[4]),
        .background_mode_permit_i(bmp), .clock_module_reset_i(src[2]),
        .supply_low_i(low), .voltage_detector_enable_i(1'b1),
        .voltage_detector_reset_enable_i(lvre), .voltage_detector_stop_enable_i(stpen),
        .stop_mode_i(stp), .pg0_data_i(pg0), .sys_reset_o(sres), .wdog_restart_o(wrst),
        .watchdog_enable_option_o(wen), .watchdog_timeout_option_o(wlong),
        .wdog_timeout_cycles_o(cyc), .halt_permit_option_o(hok), .stop_enter_o(sten),
        .lv_detect_active_o(lva), .debug_pin_enable_option_o(dpin), .pg0_o(pg0o),
        .pg0_oe_n_o(oen));
    // Compare and count
    task automatic chk(input logic [18:0] g, input logic [18:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One CPU bus cycle, read data sampled as strobes drop
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        c_rd = !w;
        c_wr = w;
        c_a = a;
        c_d = d;
        @(negedge clk_i);
        c_rd = 1'b0;
        c_wr = 1'b0;
    endtask
    // One-cycle source pulse
    task automatic pulse(input int b);
        @(negedge clk_i);
        src[b] = 1'b1;
        @(negedge clk_i);
        src[b] = 1'b0;
    endtask
    // Internal reset seen, then bounded wait for run
    task automatic wait_run();
        int i;
        @(negedge clk_i);
        chk(sres, 1);
        for (i = 0; i < 40 && sres !== 1'b0; i++) @(negedge clk_i);
        chk(sres, 0);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog on a hung run
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        close_out();
    end
    // Main sequence
    initial begin
        repeat (10) @(negedge clk_i);
        rstn_i = 1'b1;
        wait_run();
        chk(wen, 1);
        chk(wlong, 1);
        chk(cyc, 19'h40000);
        chk(hok, 0);
        chk(dpin, 1);
        chk(oen, 1);
        foreach (rows[n]) begin
            acc(rows[n].w, rows[n].a, rows[n].d);
            if (!rows[n].w) chk(rdata, rows[n].e);
            if (rows[n].w && rows[n].a == 16'h1800) chk(wrst, 1);
            chk(sres, 0);
        end
        $display("register rows done");
        foreach (causes[n]) begin
            case (causes[n].k)
                5: acc(0, causes[n].a, 8'h00);
                6: begin pin_n = 1'b0; repeat (3) @(negedge clk_i); pin_n = 1'b1; end
                7: begin low = 1'b1; repeat (3) @(negedge clk_i); low = 1'b0; end
                8: dbg_host_i.write_byte(16'h1801, 8'h01);
                default: pulse(causes[n].k);
            endcase
            wait_run();
            acc(0, 16'h1800, 8'h00);
            chk(rdata, causes[n].e);
        end
        $display("reset causes done");
        acc(1, 16'h1802, 8'h20);
        acc(0, 16'h1802, 8'h00);
        chk(rdata, 8'h20);
        chk(cyc, 19'h02000);
        chk(wen, 0);
        chk(oen, 0);
        chk(pg0o, 1);
        chk(wlong, 0);
        chk(hok, 1);
        chk(dpin, 0);
        pg0 = 1'b0;
        @(negedge clk_i);
        chk(pg0o, 0);
        pulse(0);
        @(negedge clk_i);
        chk(sres, 0);
        pulse(3);
        chk(sten, 1);
        chk(sres, 0);
        bmp = 1'b1;
        pulse(4);
        chk(sres, 0);
        dbg_host_i.write_byte(16'h1801, 8'h00);
        chk(sres, 0);
        lvre = 1'b0;
        low = 1'b1;
        repeat (4) @(negedge clk_i);
        chk(sres, 0);
        low = 1'b0;
        repeat (3) @(negedge clk_i);
        lvre = 1'b1;
        $display("options done");
        stp = 1'b1;
        repeat (2) @(negedge clk_i);
        chk(lva, 0);
        stpen = 1'b1;
        repeat (2) @(negedge clk_i);
        chk(lva, 1);
        $display("stop detector done");
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rstn_i = 1'b1;
        wait_run();
        acc(0, 16'h1800, 8'h00);
        chk(rdata, 8'h82);
        chk(oen, 1);
        $display("second power-on done");
        close_out();
    end
endmodule
